/* pkg/fir2d_pkg.sv */
// Shared constants, register map and enumerations of the 2D FIR filter
package fir2d_pkg;

  // Register byte offsets
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_COEF = 12'h100;

  // Status word layout
  localparam int STAT_FSM_LSB = 0;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_FRAMES_LSB = 16;
  localparam int FRAMES_W = 16;

  // Fraction bits of a coefficient word written by software
  localparam int CIN_FRAC = 16;

  // Headroom for result scaling, both directions
  localparam int SCALE_PAD = 16;

  // AHB-Lite encodings
  localparam int HTRANS_ACT = 1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] ADDR_ALIGN = 2'h0;

  typedef enum logic [1:0] {
    RND_TRUNC = 2'h0,
    RND_HALF_UP = 2'h1,
    RND_HALF_EVEN = 2'h2
  } rnd_t;

  typedef enum logic [0:0] {
    NEG_SAT = 1'h0,
    NEG_ABS = 1'h1
  } neg_t;

  // Gray order along load, compute, output
  typedef enum logic [1:0] {
    ST_LOAD = 2'h0,
    ST_CALC = 2'h1,
    ST_OUT = 2'h3
  } fsm_t;

endpackage

/* core/fir2d_convert.sv */
// Result to output conversion: scale, round, sign fix, constrain
`timescale 1ns/1ps
module fir2d_convert #(
  parameter int ACC_W = 32,
  parameter int FRAC = 8,
  parameter int SHIFT = 0,
  parameter fir2d_pkg::rnd_t RND = fir2d_pkg::RND_HALF_UP,
  parameter fir2d_pkg::neg_t NEG = fir2d_pkg::NEG_SAT,
  parameter int OUT_W = 8,
  parameter int OUT_MIN = 0,
  parameter int OUT_MAX = 255
)(
  input wire logic signed [ACC_W-1:0] i_acc,
  output logic [OUT_W-1:0] o_pix
);
  localparam int PAD = fir2d_pkg::SCALE_PAD;
  localparam int FB = FRAC + PAD;
  localparam int EW = ACC_W + 2 * PAD + 2;
  localparam logic signed [EW-1:0] LO = EW'(OUT_MIN);
  localparam logic signed [EW-1:0] HI = EW'(OUT_MAX);

  logic signed [EW-1:0] ext;
  logic signed [EW-1:0] ipart;
  logic signed [EW-1:0] rnd;
  logic signed [EW-1:0] mag;
  logic half;
  logic rest;

  // Four stages in fixed order; padding on both sides keeps every bit
  always_comb begin
    ext = EW'(i_acc) <<< (PAD + SHIFT);
    ipart = ext >>> FB;
    half = ext[FB-1];
    rest = |ext[FB-2:0];
    case (RND)
      fir2d_pkg::RND_HALF_UP: rnd = ipart + EW'(half);
      fir2d_pkg::RND_HALF_EVEN:
        rnd = ipart + EW'(half & (rest | ipart[0]));
      default: rnd = ipart;
    endcase
    // Saturating mode leaves negatives to the range clamp below
    if (NEG == fir2d_pkg::NEG_ABS && rnd < 0) begin
      mag = -rnd;
    end else begin
      mag = rnd;
    end
    if (mag < LO) begin
      o_pix = LO[OUT_W-1:0];
    end else if (mag > HI) begin
      o_pix = HI[OUT_W-1:0];
    end else begin
      o_pix = mag[OUT_W-1:0];
    end
  end
endmodule

/* core/fir2d_filter.sv */
// Streaming 2D FIR convolution filter with AHB-Lite coefficient port
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module fir2d_filter #(
  parameter int IN_W = 8,
  parameter int OUT_W = 8,
  parameter int COEF_W = 16,
  parameter int COEF_FRAC = 8,
  parameter int KSIZE = 3,
  parameter int PLANES = 3,
  parameter int FRAME_W = 8,
  parameter int FRAME_H = 6,
  parameter bit SYMMETRIC = 1'b0,
  parameter bit RUNTIME_COEF = 1'b1,
  parameter int SHIFT = 0,
  parameter fir2d_pkg::rnd_t RND = fir2d_pkg::RND_HALF_UP,
  parameter fir2d_pkg::neg_t NEG = fir2d_pkg::NEG_SAT,
  parameter int OUT_MIN = 0,
  parameter int OUT_MAX = (1 << OUT_W) - 1,
  parameter logic [KSIZE*KSIZE*COEF_W-1:0] COEF_FIXED = '0
)(
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [31:0] O_HRDATA,
  input wire logic I_VALID,
  input wire logic I_SOP,
  input wire logic [IN_W-1:0] I_DATA,
  output logic O_READY,
  output logic O_VALID,
  output logic O_SOP,
  output logic O_EOP,
  output logic [OUT_W-1:0] O_DATA,
  input wire logic I_READY
);
  localparam int NT = KSIZE * KSIZE;
  localparam int HALF_K = KSIZE / 2;
  localparam int NTAPS = SYMMETRIC ? NT / 2 + 1 : NT;
  localparam int DEPTH = FRAME_W * FRAME_H * PLANES;
  localparam int AW = $clog2(DEPTH);
  localparam int XW = $clog2(FRAME_W + 1);
  localparam int YW = $clog2(FRAME_H + 1);
  localparam int PW = $clog2(PLANES + 1);
  localparam int TW = $clog2(NT + 1);
  // Worst case: pixel pair times coefficient summed over every tap
  localparam int ACC_W = IN_W + COEF_W + $clog2(NT) + 3;
  localparam int DROP = fir2d_pkg::CIN_FRAC - COEF_FRAC;
  localparam logic signed [35:0] CMAX = (36'sh1 <<< (COEF_W - 1)) - 36'sh1;
  localparam logic signed [35:0] CMIN = -CMAX - 36'sh1;
  localparam logic signed [35:0] CHALF =
    (DROP > 0) ? (36'sh1 <<< (DROP - 1)) : 36'sh0;
  localparam int FW = fir2d_pkg::FRAMES_W;

  // Refuse settings the datapath cannot serve
  if (KSIZE != 3 && KSIZE != 5 && KSIZE != 7) begin : g_bad_k
    $error("KSIZE must be 3, 5 or 7");
  end
  if (IN_W < 4 || IN_W > 20 || OUT_W < 4 || OUT_W > 20) begin : g_bad_w
    $error("sample widths must be 4 to 20");
  end
  if (COEF_W < 2 || COEF_W > 35 || COEF_FRAC < 0 ||
      COEF_FRAC >= COEF_W || DROP < 0) begin : g_bad_c
    $error("coefficient format out of range");
  end
  if (SHIFT < -16 || SHIFT > 16) begin : g_bad_s
    $error("SHIFT must be -16 to 16");
  end
  if (OUT_MIN < 0 || OUT_MIN > OUT_MAX ||
      OUT_MAX > (1 << OUT_W) - 1) begin : g_bad_r
    $error("output guard bands out of range");
  end
  if (PLANES < 1 || PLANES > 3 || FRAME_W < 2 || FRAME_H < 2) begin : g_bad_f
    $error("frame geometry out of range");
  end

  typedef struct packed {
    fir2d_pkg::fsm_t fsm;
    logic [AW-1:0] wr;
    logic [XW-1:0] x;
    logic [YW-1:0] y;
    logic [PW-1:0] p;
    logic [TW-1:0] tap;
    logic signed [ACC_W-1:0] acc;
    logic [OUT_W-1:0] dat;
    logic sop;
    logic eop;
    logic [NT-1:0][COEF_W-1:0] coef;
    logic [DEPTH-1:0][IN_W-1:0] mem;
    logic hw;
    logic [31:0] ha;
    logic [31:0] rdata;
    logic [FW-1:0] frames;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // Coefficient index of a byte address, or -1 when not a coefficient
  function automatic int coef_sel(input logic [31:0] a);
    int d;
    d = int'(a[11:0]) - int'(fir2d_pkg::ADDR_COEF);
    if (a[31:12] != 20'h0 || d < 0 || a[1:0] != fir2d_pkg::ADDR_ALIGN ||
        d / 4 >= NT) begin
      return -1;
    end
    return d / 4;
  endfunction

  // Round half up from the software format, then saturate to the width
  function automatic logic [COEF_W-1:0] round_coef(input logic [31:0] w);
    logic signed [35:0] v;
    v = (36'(signed'(w)) + CHALF) >>> DROP;
    if (v > CMAX) begin
      v = CMAX;
    end else if (v < CMIN) begin
      v = CMIN;
    end
    return v[COEF_W-1:0];
  endfunction

  // True when tap t of the window centred on (x,y) falls off the frame
  function automatic bit outside(input int t, input int x, input int y);
    int px;
    int py;
    px = x + t % KSIZE - HALF_K;
    py = y + t / KSIZE - HALF_K;
    return px < 0 || px >= FRAME_W || py < 0 || py >= FRAME_H;
  endfunction

  // Sample under tap t, zero beyond any border
  function automatic logic [IN_W-1:0] get_pix(input int t, input int x,
      input int y, input int p, input logic [DEPTH-1:0][IN_W-1:0] m);
    int px;
    int py;
    px = x + t % KSIZE - HALF_K;
    py = y + t / KSIZE - HALF_K;
    if (outside(t, x, y)) begin
      return '0;
    end
    return m[(py * FRAME_W + px) * PLANES + p];
  endfunction

  logic [IN_W-1:0] pix_a_w;
  logic [IN_W-1:0] pix_b_w;
  logic [IN_W:0] pair_w;
  logic signed [ACC_W-1:0] sum_w;
  logic [OUT_W-1:0] conv_w;
  logic [COEF_W-1:0] coef_wr_w;
  int mirror_w;
  logic last_p_w;
  logic last_x_w;
  logic last_y_w;

  // Tap pixel and its mirror; pairing shares one multiply per tap pair
  assign mirror_w = NT - 1 - int'(s_r.tap);
  assign pix_a_w = get_pix(int'(s_r.tap), int'(s_r.x), int'(s_r.y),
                           int'(s_r.p), s_r.mem);
  assign pix_b_w = (SYMMETRIC && mirror_w != int'(s_r.tap)) ?
    get_pix(mirror_w, int'(s_r.x), int'(s_r.y), int'(s_r.p), s_r.mem) :
    '0;
  assign pair_w = {1'h0, pix_a_w} + {1'h0, pix_b_w};
  // Operands widened before the product so no bit is lost
  assign sum_w = s_r.acc + ACC_W'(signed'({1'h0, pair_w})) *
    ACC_W'(signed'(s_r.coef[s_r.tap]));
  assign coef_wr_w = round_coef(I_HWDATA);

  // Position of the current output sample, plane order kept
  assign last_p_w = s_r.p == PW'(PLANES - 1);
  assign last_x_w = s_r.x == XW'(FRAME_W - 1);
  assign last_y_w = s_r.y == YW'(FRAME_H - 1);

  fir2d_convert #(
    .ACC_W(ACC_W),
    .FRAC(COEF_FRAC),
    .SHIFT(SHIFT),
    .RND(RND),
    .NEG(NEG),
    .OUT_W(OUT_W),
    .OUT_MIN(OUT_MIN),
    .OUT_MAX(OUT_MAX)
  ) u_convert (
    .i_acc(sum_w),
    .o_pix(conv_w)
  );

  // Next state: bus slave, frame store, tap walk, output hold
  always_comb begin
    int sel;
    logic [AW-1:0] widx;
    sel = coef_sel(s_r.ha);
    widx = s_r.wr;
    s_nxt = s_r;
    // Data phase of a write; read data below sees it at once
    if (s_r.hw && sel >= 0 && RUNTIME_COEF) begin
      s_nxt.coef[sel] = coef_wr_w;
    end
    s_nxt.hw = 1'h0;
    if (I_HREADY && I_HSEL && I_HTRANS[fir2d_pkg::HTRANS_ACT]) begin
      s_nxt.hw = I_HWRITE && I_HSIZE == fir2d_pkg::HSIZE_WORD;
      s_nxt.ha = I_HADDR;
      s_nxt.rdata = '0;
      if (!I_HWRITE) begin
        sel = coef_sel(I_HADDR);
        if (I_HADDR == 32'(fir2d_pkg::ADDR_STATUS)) begin
          s_nxt.rdata[fir2d_pkg::STAT_FSM_LSB+:2] = s_r.fsm;
          s_nxt.rdata[fir2d_pkg::STAT_BUSY_BIT] =
            s_r.fsm != fir2d_pkg::ST_LOAD;
          s_nxt.rdata[fir2d_pkg::STAT_FRAMES_LSB+:FW] = s_r.frames;
        end else if (sel >= 0) begin
          s_nxt.rdata = 32'(signed'(s_nxt.coef[sel]));
        end
      end
    end
    case (s_r.fsm)
      fir2d_pkg::ST_LOAD: begin
        // A start of packet restarts the frame at its first sample
        if (I_VALID) begin
          widx = I_SOP ? '0 : s_r.wr;
          s_nxt.mem[widx] = I_DATA;
          if (widx == AW'(DEPTH - 1)) begin
            s_nxt.wr = '0;
            s_nxt.fsm = fir2d_pkg::ST_CALC;
            s_nxt.x = '0;
            s_nxt.y = '0;
            s_nxt.p = '0;
            s_nxt.tap = '0;
            s_nxt.acc = '0;
          end else begin
            s_nxt.wr = widx + 1'h1;
          end
        end
      end
      fir2d_pkg::ST_CALC: begin
        // One tap per cycle; one multiplier serves the whole kernel
        s_nxt.acc = sum_w;
        if (s_r.tap == TW'(NTAPS - 1)) begin
          s_nxt.dat = conv_w;
          s_nxt.sop = s_r.x == '0 && s_r.y == '0 && s_r.p == '0;
          s_nxt.eop = last_p_w && last_x_w && last_y_w;
          s_nxt.fsm = fir2d_pkg::ST_OUT;
        end else begin
          s_nxt.tap = s_r.tap + 1'h1;
        end
      end
      fir2d_pkg::ST_OUT: begin
        // Result holds until the sink takes it
        if (I_READY) begin
          s_nxt.sop = 1'h0;
          s_nxt.eop = 1'h0;
          s_nxt.tap = '0;
          s_nxt.acc = '0;
          s_nxt.fsm = fir2d_pkg::ST_CALC;
          s_nxt.p = s_r.p + 1'h1;
          if (last_p_w) begin
            s_nxt.p = '0;
            s_nxt.x = s_r.x + 1'h1;
            if (last_x_w) begin
              s_nxt.x = '0;
              s_nxt.y = s_r.y + 1'h1;
              if (last_y_w) begin
                s_nxt.y = '0;
                s_nxt.fsm = fir2d_pkg::ST_LOAD;
                s_nxt.frames = s_r.frames + 1'h1;
              end
            end
          end
        end
      end
      default: s_nxt.fsm = fir2d_pkg::ST_LOAD;
    endcase
  end

  // State register; coefficients start from the build-time set
  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      s_r <= '0;
      s_r.coef <= COEF_FIXED;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Zero wait state slave, always OKAY
  assign O_HREADYOUT = 1'h1;
  assign O_HRESP = 1'h0;
  assign O_HRDATA = s_r.rdata;
  assign O_READY = s_r.fsm == fir2d_pkg::ST_LOAD;
  assign O_VALID = s_r.fsm == fir2d_pkg::ST_OUT;
  assign O_SOP = s_r.sop;
  assign O_EOP = s_r.eop;
  assign O_DATA = s_r.dat;

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);

  AST_NO_TAKE_BUSY: assert property (
    s_r.fsm != fir2d_pkg::ST_LOAD |=> $stable(s_r.wr)
  ) else $error("input index moved while not loading");

  AST_OUT_HOLD: assert property (
    O_VALID && !I_READY |=> O_VALID && $stable(O_DATA) && $stable(O_SOP)
  ) else $error("output changed under back-pressure");

  AST_FRAME_FULL: assert property (
    O_READY && I_VALID && !I_SOP && s_r.wr == AW'(DEPTH - 1)
    |=> s_r.fsm == fir2d_pkg::ST_CALC && s_r.tap == '0 && !O_READY
  ) else $error("full frame did not start computing");

  AST_TAP_END: assert property (
    s_r.fsm == fir2d_pkg::ST_CALC && s_r.tap == TW'(NTAPS - 1)
    |=> O_VALID && O_DATA == $past(conv_w)
  ) else $error("last tap did not present a result");

  AST_PAD_ZERO: assert property (
    s_r.fsm == fir2d_pkg::ST_CALC &&
    outside(int'(s_r.tap), int'(s_r.x), int'(s_r.y)) |-> pix_a_w == '0
  ) else $error("pixel outside frame not zero");

  AST_RANGE: assert property (
    O_VALID |-> int'(O_DATA) >= OUT_MIN && int'(O_DATA) <= OUT_MAX
  ) else $error("output outside range");

  AST_CENTRE: assert property (
    O_VALID && O_SOP |-> s_r.x == '0 && s_r.y == '0 && s_r.p == '0
  ) else $error("first output not at first centre");

  AST_COEF_WR: assert property (
    RUNTIME_COEF && s_r.hw && s_r.ha == 32'(fir2d_pkg::ADDR_COEF)
    |=> s_r.coef[0] == $past(coef_wr_w)
  ) else $error("coefficient write not stored rounded");

  AST_CALC_LEN: assert property (
    $rose(s_r.fsm == fir2d_pkg::ST_CALC) |-> ##NTAPS O_VALID
  ) else $error("tap walk length wrong");

  COV_FRAME: cover property (O_VALID && O_EOP && I_READY);
  COV_STALL: cover property (O_VALID && !I_READY ##1 O_VALID && I_READY);
  COV_COEF: cover property (s_r.hw && coef_sel(s_r.ha) >= 0);
  COV_RESYNC: cover property (O_READY && I_VALID && I_SOP && s_r.wr != '0);
endmodule

/* test/fir2d_sink_model.sv */
// Downstream video sink model that takes samples promptly or slowly
`timescale 1ns/1ps
module fir2d_sink_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_stall,
  output logic o_ready
);
  logic [2:0] slot_r;

  // Free running slot counter paces the slow mode
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slot_r <= 3'h0;
    end else begin
      slot_r <= slot_r + 3'h1;
    end
  end

  // Slow mode takes two of every eight cycles, so the filter must hold
  // its output through long back-pressure
  assign o_ready = !i_stall || slot_r == 3'h0 || slot_r == 3'h5;
endmodule

/* test/video_2d_fir_filter_tb.sv */
// Self-checking bench of the 2D FIR filter and its coefficient port
`timescale 1ns/1ps
module video_2d_fir_filter_tb;
  localparam int FW = 4;
  localparam int FH = 3;
  localparam int NPIX = FW * FH;
  // Scale and guard bands of the symmetric, truncating filter
  localparam int SH = 1;
  localparam int LO_C = 16;
  localparam int HI_C = 235;
  logic ref_clk, rst_n, hsel, hwrite, valid, sop, stall, hready, hresp;
  logic ready, ovalid, osop, oeop, sink_rdy;
  logic ovalid_c, osop_c, oeop_c;
  logic [31:0] haddr, hwdata, hrdata, lfsr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] din, dout_a, dout_b, dout_c;
  logic [7:0] pix [NPIX];
  int cf [9];
  logic [17:0] exp_q [$];
  logic [9:0] exp_c_q [$];
  int err_total, checked;

  // Half-up rounding with saturation of negatives
  fir2d_filter #(.FRAME_W(FW), .FRAME_H(FH), .PLANES(1)) fir2d_filter_i (
    .I_REF_CLK(ref_clk), .I_RESETN(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HREADYOUT(hready),
    .O_HRESP(hresp), .O_HRDATA(hrdata), .I_VALID(valid), .I_SOP(sop),
    .I_DATA(din), .O_READY(ready), .O_VALID(ovalid), .O_SOP(osop),
    .O_EOP(oeop), .O_DATA(dout_a), .I_READY(sink_rdy));

  // Same traffic, half-even rounding and absolute value of negatives
  fir2d_filter #(.FRAME_W(FW), .FRAME_H(FH), .PLANES(1),
    .RND(fir2d_pkg::RND_HALF_EVEN), .NEG(fir2d_pkg::NEG_ABS))
    fir2d_filter_abs_i (
    .I_REF_CLK(ref_clk), .I_RESETN(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HREADYOUT(),
    .O_HRESP(), .O_HRDATA(), .I_VALID(valid), .I_SOP(sop),
    .I_DATA(din), .O_READY(), .O_VALID(), .O_SOP(),
    .O_EOP(), .O_DATA(dout_b), .I_READY(sink_rdy));

  // Symmetric taps, truncation, scale-up and narrower guard bands; it
  // finishes its tap walk sooner, so it has its own output queue
  fir2d_filter #(.FRAME_W(FW), .FRAME_H(FH), .PLANES(1), .SYMMETRIC(1'b1),
    .SHIFT(SH), .RND(fir2d_pkg::RND_TRUNC), .OUT_MIN(LO_C),
    .OUT_MAX(HI_C))
    fir2d_filter_sym_i (
    .I_REF_CLK(ref_clk), .I_RESETN(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hready), .O_HREADYOUT(),
    .O_HRESP(), .O_HRDATA(), .I_VALID(valid), .I_SOP(sop),
    .I_DATA(din), .O_READY(), .O_VALID(ovalid_c), .O_SOP(osop_c),
    .O_EOP(oeop_c), .O_DATA(dout_c), .I_READY(sink_rdy));

  fir2d_sink_model fir2d_sink_model_i (.i_clk(ref_clk), .i_rst_n(rst_n),
    .i_stall(stall), .o_ready(sink_rdy));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One single AHB transfer; read data is taken at the data phase edge
  task automatic ahb(input logic w, input logic [31:0] a,
    input logic [31:0] d, input logic [2:0] sz, output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    @(posedge ref_clk);
    while (!hready) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (!hready) @(posedge ref_clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Write a coefficient in 16 fraction bits and read back the rounded form
  task automatic set_coef(input int t, input int w);
    logic [31:0] rd;
    logic [31:0] a;
    a = 32'(fir2d_pkg::ADDR_COEF) + 32'(4 * t);
    cf[t] = (w + 128) >>> 8;
    ahb(1'b1, a, 32'(w), fir2d_pkg::HSIZE_WORD, rd);
    ahb(1'b0, a, 32'h0, fir2d_pkg::HSIZE_WORD, rd);
    chk(rd, 32'(cf[t]));
  endtask

  // Expected outputs for the pixel at column x, row y; the symmetric
  // filter reuses the coefficient of the mirror tap past the centre
  function automatic logic [23:0] model(input int x, input int y);
    int acc, sym, a, b, c, xx, yy;
    acc = 0;
    sym = 0;
    for (int t = 0; t < 9; t++) begin
      xx = x + t % 3 - 1;
      yy = y + t / 3 - 1;
      if (xx >= 0 && xx < FW && yy >= 0 && yy < FH) begin
        acc += cf[t] * int'(pix[yy * FW + xx]);
        sym += cf[t < 5 ? t : 8 - t] * int'(pix[yy * FW + xx]);
      end
    end
    a = (acc + 128) >>> 8;
    b = acc >>> 8;
    if ((acc & 255) > 128 || ((acc & 255) == 128 && b[0])) begin
      b++;
    end
    if (b < 0) begin
      b = -b;
    end
    a = a < 0 ? 0 : (a > 255 ? 255 : a);
    b = b > 255 ? 255 : b;
    // Truncation floors; the scale-up leaves fewer fraction bits to drop
    c = sym >>> (8 - SH);
    c = c < LO_C ? LO_C : (c > HI_C ? HI_C : c);
    return {a[7:0], b[7:0], c[7:0]};
  endfunction

  // Note the whole frame of results, then feed samples with random gaps
  task automatic send_frame;
    logic [23:0] m;
    for (int i = 0; i < NPIX; i++) begin
      m = model(i % FW, i / FW);
      exp_q.push_back({i == 0, i == NPIX - 1, m[23:8]});
      exp_c_q.push_back({i == 0, i == NPIX - 1, m[7:0]});
    end
    for (int i = 0; i < NPIX; i++) begin
      lfsr = lfsr_next(lfsr);
      if (lfsr[0]) begin
        valid <= 1'b0;
        din <= ~din;
        @(posedge ref_clk);
      end
      valid <= 1'b1;
      sop <= (i == 0);
      din <= pix[i];
      @(posedge ref_clk);
      while (!ready) @(posedge ref_clk);
    end
    valid <= 1'b0;
    sop <= 1'b0;
    din <= ~din;
  endtask

  // Output watcher: each taken sample retires the oldest note
  always @(posedge ref_clk) begin
    if (rst_n && ovalid && sink_rdy) begin
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        chk({14'h0, osop, oeop, dout_a, dout_b},
          32'(exp_q.pop_front()));
      end
    end
  end

  // Watcher of the symmetric filter, which runs ahead of the other two
  always @(posedge ref_clk) begin
    if (rst_n && ovalid_c && sink_rdy) begin
      if (exp_c_q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        chk({22'h0, osop_c, oeop_c, dout_c},
          32'(exp_c_q.pop_front()));
      end
    end
  end

  // Five frames take about one thousand cycles; this leaves ample margin
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] rd;
    int w;
    {hsel, hwrite, valid, sop, stall} = 5'h0;
    {haddr, hwdata, din, htrans, hsize} = '0;
    lfsr = 32'h6729;
    err_total = 0;
    checked = 0;
    rst_n = 1'b0;
    repeat (20) @(posedge ref_clk);
    chk({30'h0, ready, ovalid}, 32'h2);
    rst_n <= 1'b1;
    ahb(1'b1, 32'(fir2d_pkg::ADDR_STATUS), 32'hffffffff, 3'h2, rd);
    ahb(1'b0, 32'(fir2d_pkg::ADDR_STATUS), 32'h0, 3'h2, rd);
    chk(rd, 32'h0);
    set_coef(0, 32'h180);
    ahb(1'b1, 32'(fir2d_pkg::ADDR_COEF), 32'h10000, 3'h0, rd);
    ahb(1'b0, 32'(fir2d_pkg::ADDR_COEF), 32'h0, 3'h2, rd);
    chk(rd, 32'h2);
    ahb(1'b0, 32'h80, 32'h0, 3'h2, rd);
    chk(rd, 32'h0);
    $display("test registers done");
    // Shift kernel, plus and minus one half, then random kernels
    for (int f = 0; f < 5; f++) begin
      stall <= (f % 2 == 1);
      for (int t = 0; t < 9; t++) begin
        lfsr = lfsr_next(lfsr);
        w = f > 2 ? int'(lfsr[17:0]) - 131072 : 0;
        w = (f == 0 && t == 5) ? 65536 : w;
        w = (f == 1 && t == 4) ? 32768 : w;
        w = (f == 2 && t == 4) ? -32768 : w;
        set_coef(t, w);
      end
      for (int i = 0; i < NPIX; i++) begin
        lfsr = lfsr_next(lfsr);
        pix[i] = lfsr[7:0];
      end
      send_frame();
      while (exp_q.size() != 0 || exp_c_q.size() != 0) @(posedge ref_clk);
      @(posedge ref_clk);
      $display("test frame %0d done", f);
    end
    ahb(1'b0, 32'(fir2d_pkg::ADDR_STATUS), 32'h0, 3'h2, rd);
    chk(rd, 32'h00050000);
    tally_and_finish();
  end
endmodule
